// ### channel_mode_jitter_attenuator_config.sv
// channel configuration, soft reset and tx/rx jitter attenuator control
//
// Contract
// - writing one to the soft reset bit resets this channel only, done within 1 us.
// - the soft reset bit clears itself once the reset is over.
// - line standard select is T1/J1 at zero (reset default) and E1 at one.
// - line standard select keeps its value through the channel soft reset.
// - tx limit mode, off by default, adjusts output rate within 2 bits of full or empty.
// - the tx attenuator works only while its enable bit is one, off by default.
// - tx fifo depth code 00 gives 128 bits (default), 01 gives 64, 1x gives 32.
// - tx bandwidth bit picks 5 Hz / 6.77 Hz at zero and 1.26 Hz / 0.87 Hz at one.
// - rx limit mode, off by default, adjusts output rate within 2 bits of full or empty.
// - the rx attenuator works only while its enable bit is one, off by default.
// - rx fifo depth code 00 gives 128 bits (default), 01 gives 64, 1x gives 32.
// - rx bandwidth bit picks 5 Hz / 6.77 Hz at zero and 1.26 Hz / 0.87 Hz at one.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module channel_mode_jitter_attenuator_config
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic [1:0] ja_in_valid,
  input  wire logic [1:0] ja_in_bit,
  input  wire logic [1:0] ja_out_tick,
  output var  logic [1:0] ja_out_valid,
  output var  logic [1:0] ja_out_bit,
  output var  logic [1:0] ja_speed_up,
  output var  logic [1:0] ja_slow_down,
  output var  logic [1:0] ja_active,
  output var  logic [3:0] ja_corner,
  output var  logic       line_standard,
  output var  logic       channel_reset
);

  // path 0 is transmit, path 1 is receive
  localparam int unsigned TX = 0;
  localparam int unsigned RX = 1;

  logic [7:0]                         rdata_reg;
  logic                               line_std_reg;
  logic [4:0]                         ja_cfg_reg [2];
  chan_cfg_pkg::soft_reset_state_t    rst_state_reg;
  chan_cfg_pkg::soft_reset_state_t    rst_state_next;
  logic [7:0]                         rst_count_reg;
  logic [7:0]                         rst_count_next;
  logic                               soft_rst_req;
  logic                               in_reset;
  logic [1:0]                         cfg_write;

  assign reg_rdata     = rdata_reg;
  assign soft_rst_req  = reg_wr && (reg_addr == chan_cfg_pkg::CHANNEL_CONFIG_OFFSET)
                         && reg_wdata[chan_cfg_pkg::SOFT_RESET_BIT];
  assign in_reset      = (rst_state_reg == chan_cfg_pkg::RST_ACTIVE);
  assign cfg_write[TX] = reg_wr && (reg_addr == chan_cfg_pkg::TX_JA_CONFIG_OFFSET);
  assign cfg_write[RX] = reg_wr && (reg_addr == chan_cfg_pkg::RX_JA_CONFIG_OFFSET);

  // soft reset sequencer; a new request restarts the hold count
  always_comb
  begin
    rst_state_next = rst_state_reg;
    rst_count_next = rst_count_reg;
    case (rst_state_reg)
      chan_cfg_pkg::RST_IDLE:
      begin
        if (soft_rst_req)
        begin
          rst_state_next = chan_cfg_pkg::RST_ACTIVE;
          rst_count_next = chan_cfg_pkg::SOFT_RESET_LOAD;
        end
      end
      chan_cfg_pkg::RST_ACTIVE:
      begin
        if (soft_rst_req)
        begin
          rst_count_next = chan_cfg_pkg::SOFT_RESET_LOAD;
        end
        else if (rst_count_reg == 8'h00)
        begin
          rst_state_next = chan_cfg_pkg::RST_IDLE;
        end
        else
        begin
          rst_count_next = rst_count_reg - 8'h01;
        end
      end
      default:
      begin
        rst_state_next = chan_cfg_pkg::RST_IDLE;
        rst_count_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_state_reg <= chan_cfg_pkg::RST_IDLE;
      rst_count_reg <= 8'h00;
      channel_reset <= 1'b0;
    end
    else
    begin
      rst_state_reg <= rst_state_next;
      rst_count_reg <= rst_count_next;
      channel_reset <= (rst_state_next == chan_cfg_pkg::RST_ACTIVE);
    end
  end

  // line standard lives outside the soft reset domain
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      line_std_reg <= chan_cfg_pkg::CHANNEL_CONFIG_RESET[chan_cfg_pkg::LINE_STD_BIT];
    end
    else if (reg_wr && (reg_addr == chan_cfg_pkg::CHANNEL_CONFIG_OFFSET))
    begin
      line_std_reg <= reg_wdata[chan_cfg_pkg::LINE_STD_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      line_standard <= chan_cfg_pkg::LINE_T1J1;
    end
    else
    begin
      line_standard <= line_std_reg;
    end
  end

  // attenuator config; soft reset returns it to default, writes during reset are lost
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ja_cfg_reg[TX] <= chan_cfg_pkg::JA_CONFIG_RESET[4:0];
      ja_cfg_reg[RX] <= chan_cfg_pkg::JA_CONFIG_RESET[4:0];
    end
    else if (in_reset)
    begin
      ja_cfg_reg[TX] <= chan_cfg_pkg::JA_CONFIG_RESET[4:0];
      ja_cfg_reg[RX] <= chan_cfg_pkg::JA_CONFIG_RESET[4:0];
    end
    else
    begin
      if (cfg_write[TX])
      begin
        ja_cfg_reg[TX] <= reg_wdata[4:0];
      end
      if (cfg_write[RX])
      begin
        ja_cfg_reg[RX] <= reg_wdata[4:0];
      end
    end
  end

  // read port; data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        chan_cfg_pkg::CHANNEL_CONFIG_OFFSET:
          rdata_reg <= {6'h00, in_reset, line_std_reg};
        chan_cfg_pkg::TX_JA_CONFIG_OFFSET:
          rdata_reg <= {3'h0, ja_cfg_reg[TX]};
        chan_cfg_pkg::RX_JA_CONFIG_OFFSET:
          rdata_reg <= {3'h0, ja_cfg_reg[RX]};
        default:
          rdata_reg <= 8'h00;
      endcase
    end
    else
    begin
      rdata_reg <= 8'h00;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_path
      logic                 en;
      logic                 limit;
      logic [7:0]           depth;
      logic [7:0]           mask;
      logic [6:0]           wr_ptr_reg;
      logic [6:0]           rd_ptr_reg;
      logic [7:0]           fill_reg;
      logic [7:0]           fill_next;
      logic [1:0]           cfg_shadow_reg;
      logic                 flush;
      logic                 near_full;
      logic                 near_empty;
      logic                 speed;
      logic                 slow;
      logic                 do_rd;
      logic                 do_wr;
      logic                 rd_pend_reg;
      logic                 mem_bit;

      assign en    = ja_cfg_reg[p][chan_cfg_pkg::JA_EN_BIT];
      assign limit = ja_cfg_reg[p][chan_cfg_pkg::FIFO_LIMIT_RATE_ADJUST_BIT];
      assign depth = chan_cfg_pkg::fifo_depth(
                       ja_cfg_reg[p][chan_cfg_pkg::JA_DP_MSB:chan_cfg_pkg::JA_DP_LSB]);
      assign mask  = depth - 8'h01;
      // an enable change, or a depth change to or from 128 bits, would leave stale pointers, so it empties the fifo; 64 to 32 does not
      assign flush = in_reset || (cfg_shadow_reg != {en, depth == chan_cfg_pkg::DEPTH_128});

      assign near_full  = fill_reg >= (depth - chan_cfg_pkg::LIMIT_MARGIN);
      assign near_empty = fill_reg <= chan_cfg_pkg::LIMIT_MARGIN;
      assign speed      = limit && near_full;
      assign slow       = limit && near_empty;

      // near empty holds reads back, near full adds reads on input bits
      assign do_rd = en && !flush && (fill_reg != 8'h00)
                     && ((ja_out_tick[p] && !slow)
                         || (speed && ja_in_valid[p] && !ja_out_tick[p]));
      // without limit mode an input bit into a full fifo is dropped unless an output tick reads in the same cycle
      assign do_wr = en && !flush && ja_in_valid[p] && ((fill_reg < depth) || do_rd);

      always_comb
      begin
        fill_next = fill_reg;
        if (do_wr && !do_rd)
        begin
          fill_next = fill_reg + 8'h01;
        end
        else if (do_rd && !do_wr)
        begin
          fill_next = fill_reg - 8'h01;
        end
      end

      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          wr_ptr_reg     <= 7'h00;
          rd_ptr_reg     <= 7'h00;
          fill_reg       <= 8'h00;
          cfg_shadow_reg <= 2'b01;
        end
        else
        begin
          cfg_shadow_reg <= {en, depth == chan_cfg_pkg::DEPTH_128};
          if (flush)
          begin
            wr_ptr_reg <= 7'h00;
            rd_ptr_reg <= 7'h00;
            fill_reg   <= 8'h00;
          end
          else
          begin
            if (do_wr)
            begin
              wr_ptr_reg <= (wr_ptr_reg + 7'h01) & mask[6:0];
            end
            if (do_rd)
            begin
              rd_ptr_reg <= (rd_ptr_reg + 7'h01) & mask[6:0];
            end
            fill_reg <= fill_next;
          end
        end
      end

      ja_bit_mem u_mem
      (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .wr_en      (do_wr),
        .wr_addr    (wr_ptr_reg),
        .wr_bit     (ja_in_bit[p]),
        .rd_en      (do_rd),
        .rd_addr    (rd_ptr_reg),
        .rd_bit_reg (mem_bit)
      );

      // disabled path passes bits straight through with the same latency as a flop
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          rd_pend_reg     <= 1'b0;
          ja_out_valid[p] <= 1'b0;
          ja_out_bit[p]   <= 1'b0;
          ja_speed_up[p]  <= 1'b0;
          ja_slow_down[p] <= 1'b0;
          ja_active[p]    <= 1'b0;
          ja_corner[2*p+1 -: 2] <= chan_cfg_pkg::CORNER_5HZ;
        end
        else
        begin
          rd_pend_reg     <= do_rd;
          ja_out_valid[p] <= en ? rd_pend_reg : (ja_in_valid[p] && !in_reset);
          ja_out_bit[p]   <= en ? mem_bit : ja_in_bit[p];
          ja_speed_up[p]  <= en && speed;
          ja_slow_down[p] <= en && slow;
          ja_active[p]    <= en;
          ja_corner[2*p+1 -: 2] <= chan_cfg_pkg::corner_of(line_std_reg,
                                     ja_cfg_reg[p][chan_cfg_pkg::JA_BW_BIT]);
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### chan_cfg_pkg.sv
// constants, types and helpers shared by the channel configuration block
package chan_cfg_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // per-channel register offsets
  localparam logic [5:0] CHANNEL_CONFIG_OFFSET = 6'h01;
  localparam logic [5:0] TX_JA_CONFIG_OFFSET   = 6'h02;
  localparam logic [5:0] RX_JA_CONFIG_OFFSET   = 6'h03;

  // channel_config fields
  localparam int unsigned LINE_STD_BIT   = 0;
  localparam int unsigned SOFT_RESET_BIT = 1;

  // jitter attenuator config fields
  localparam int unsigned JA_BW_BIT    = 0;
  localparam int unsigned JA_DP_LSB    = 1;
  localparam int unsigned JA_DP_MSB    = 2;
  localparam int unsigned JA_EN_BIT    = 3;
  localparam int unsigned FIFO_LIMIT_RATE_ADJUST_BIT = 4;

  localparam logic [7:0] JA_USED_MASK         = 8'h1f;
  localparam logic [7:0] CHANNEL_CONFIG_RESET = 8'h00;
  localparam logic [7:0] JA_CONFIG_RESET      = 8'h00;

  localparam logic LINE_T1J1 = 1'b0;
  localparam logic LINE_E1   = 1'b1;

  // fifo geometry, in bits
  localparam int unsigned JA_MEM_DEPTH = 128;
  localparam int unsigned JA_PTR_W     = 7;
  localparam int unsigned JA_FILL_W    = 8;
  localparam logic [7:0]  DEPTH_128    = 8'h80;
  localparam logic [7:0]  DEPTH_64     = 8'h40;
  localparam logic [7:0]  DEPTH_32     = 8'h20;
  localparam logic [7:0]  LIMIT_MARGIN = 8'h02;

  // soft reset timing
  localparam int unsigned CLK_PERIOD_NS          = 5;
  localparam int unsigned SOFT_RESET_MAX_NS      = 1000;
  localparam int unsigned SOFT_RESET_MAX_CYCLES  = SOFT_RESET_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RESET_HOLD_CYCLES = 16;
  localparam logic [7:0]  SOFT_RESET_LOAD        = 8'(SOFT_RESET_HOLD_CYCLES - 1);

  typedef enum logic [0:0]
  {
    RST_IDLE   = 1'b0,
    RST_ACTIVE = 1'b1
  } soft_reset_state_t;

  // corner code is {line standard, bandwidth bit}
  typedef enum logic [1:0]
  {
    CORNER_5HZ    = 2'b00,
    CORNER_1P26HZ = 2'b01,
    CORNER_6P77HZ = 2'b10,
    CORNER_0P87HZ = 2'b11
  } corner_t;

  function automatic corner_t corner_of(input logic line_std, input logic bw);
    case ({line_std, bw})
      2'b00:   corner_of = CORNER_5HZ;
      2'b01:   corner_of = CORNER_1P26HZ;
      2'b10:   corner_of = CORNER_6P77HZ;
      default: corner_of = CORNER_0P87HZ;
    endcase
  endfunction

  function automatic logic [7:0] fifo_depth(input logic [1:0] code);
    case (code)
      2'b00:   fifo_depth = DEPTH_128;
      2'b01:   fifo_depth = DEPTH_64;
      default: fifo_depth = DEPTH_32;
    endcase
  endfunction

endpackage

// ### ja_bit_mem.sv
// single-bit storage of one jitter attenuator fifo, registered read
`timescale 1ns/10ps
`default_nettype none
module ja_bit_mem
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic       wr_bit,
  input  wire logic       rd_en,
  input  wire logic [6:0] rd_addr,
  output var  logic       rd_bit_reg
);

  logic [chan_cfg_pkg::JA_MEM_DEPTH-1:0] mem_reg;

  // contents need no reset; the pointers decide what is valid
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_bit;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_bit_reg <= 1'b0;
    end
    else if (rd_en)
    begin
      rd_bit_reg <= mem_reg[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ### chan_cfg_chk.sv
// port assertions for the channel configuration block
`timescale 1ns/10ps
`default_nettype none
module chan_cfg_chk
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] ja_speed_up,
  input wire logic [1:0] ja_slow_down,
  input wire logic [1:0] ja_active,
  input wire logic [3:0] ja_corner,
  input wire logic       line_standard,
  input wire logic       channel_reset
);
  logic ch_wr;
  logic tx_wr;
  logic rx_wr;
  assign ch_wr = reg_wr && reg_addr == 6'h01;
  // config writes are dropped while the channel reset runs
  assign tx_wr = reg_wr && reg_addr == 6'h02 && !channel_reset;
  assign rx_wr = reg_wr && reg_addr == 6'h03 && !channel_reset;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_soft_req;
    ch_wr && reg_wdata[1];
  endsequence
  sequence s_quiet;
    !ch_wr ##1 !ch_wr;
  endsequence

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_ja_reserved: assert property (reg_rd && reg_addr[5:1] == 5'h01
    |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits read nonzero");
  a_soft_start: assert property (s_soft_req |=> channel_reset)
    else $error("soft reset did not start");
  a_soft_done: assert property ($rose(channel_reset)
    |-> ##[1:200] !channel_reset) else $error("soft reset too long");
  a_line_write: assert property (ch_wr |-> ##2 line_standard == $past(reg_wdata[0], 2))
    else $error("line standard not stored");
  a_line_keep: assert property (s_quiet |=> $stable(line_standard))
    else $error("line standard changed unasked");
  a_tx_cfg_out: assert property (tx_wr |-> ##2
    ja_active[0] == $past(reg_wdata[3], 2) && ja_corner[0] == $past(reg_wdata[0], 2))
    else $error("tx config not applied");
  a_rx_cfg_out: assert property (rx_wr |-> ##2
    ja_active[1] == $past(reg_wdata[3], 2) && ja_corner[2] == $past(reg_wdata[0], 2))
    else $error("rx config not applied");
  a_limit_excl: assert property ((ja_speed_up & ja_slow_down) == 2'h0)
    else $error("speed up and slow down together");
endmodule
bind channel_mode_jitter_attenuator_config chan_cfg_chk u_chk (.*);
`default_nettype wire

// ### channel_mode_jitter_attenuator_config_tb.sv
// self-checking bench for the channel configuration block
`timescale 1ns/10ps
`default_nettype none
module channel_mode_jitter_attenuator_config_tb;
  logic       core_clk = 1'h0;
  logic       nrst = 1'h0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic [1:0] ja_in_valid = 2'h0;
  logic [1:0] ja_in_bit = 2'h0;
  logic [1:0] ja_out_tick = 2'h0;
  logic [7:0] reg_rdata;
  logic [1:0] ja_out_valid;
  logic [1:0] ja_out_bit;
  logic [1:0] ja_speed_up;
  logic [1:0] ja_slow_down;
  logic [1:0] ja_active;
  logic [3:0] ja_corner;
  logic       line_standard;
  logic       channel_reset;
  int         num_errors = 0;
  int         num_checks = 0;

  channel_mode_jitter_attenuator_config uut (.*);

  always #2.5 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(n, e, reg_rdata);
  endtask

  function automatic logic pat(input int i);
    return i[0] ^ i[3];
  endfunction

  task automatic feed(input int p, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      ja_in_valid[p] <= 1'h1;
      ja_in_bit[p] <= pat(i);
    end
    @(posedge core_clk);
    ja_in_valid[p] <= 1'h0;
  endtask

  task automatic drain(input int p, input int k, output int cnt);
    cnt = 0;
    for (int i = 0; i < k + 4; i++)
    begin
      @(posedge core_clk);
      ja_out_tick[p] <= (i < k);
      #1;
      if (ja_out_valid[p] === 1'h1)
      begin
        chk("order", {7'h0, pat(cnt)}, {7'h0, ja_out_bit[p]});
        cnt++;
      end
    end
  endtask

  task automatic t_regs();
    chk("active", 8'h00, {6'h0, ja_active});
    chk("line", 8'h00, {7'h0, line_standard});
    rd(6'h01, 8'h00, "ch_cfg");
    rd(6'h02, 8'h00, "tx_cfg");
    rd(6'h03, 8'h00, "rx_cfg");
    rd(6'h3f, 8'h00, "unmapped");
    wr(6'h02, 8'hff);
    rd(6'h02, 8'h1f, "tx_rsvd");
    wr(6'h03, 8'he0);
    rd(6'h03, 8'h00, "rx_rsvd");
    wr(6'h01, 8'hfc);
    rd(6'h01, 8'h00, "ch_rsvd");
    wr(6'h02, 8'h00);
  endtask

  task automatic t_corner();
    for (int k = 0; k < 4; k++)
    begin
      wr(6'h01, {7'h0, k[1]});
      wr(6'h02, {7'h0, k[0]});
      wr(6'h03, {7'h0, ~k[0]});
      cyc(3);
      chk("corner", {4'h0, k[1], ~k[0], k[1], k[0]}, {4'h0, ja_corner});
      chk("line", {7'h0, k[1]}, {7'h0, line_standard});
    end
  endtask

  task automatic t_soft();
    int n;
    wr(6'h01, 8'h01);
    wr(6'h02, 8'h1d);
    wr(6'h03, 8'h0b);
    wr(6'h01, 8'h03);
    #1 chk("ch_rst", 8'h01, {7'h0, channel_reset});
    rd(6'h01, 8'h03, "ch_busy");
    wr(6'h02, 8'h08);
    n = 0;
    while (channel_reset === 1'h1 && n < 300)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("rst_time", 8'h01, {7'h0, n < 196});
    chk("line_kept", 8'h01, {7'h0, line_standard});
    rd(6'h01, 8'h01, "ch_done");
    rd(6'h02, 8'h00, "tx_clr");
    rd(6'h03, 8'h00, "rx_clr");
  endtask

  // disabled attenuator passes bits straight through
  task automatic t_bypass(input int p);
    int j;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge core_clk);
      ja_in_valid[p] <= (i < 6) && !i[0];
      ja_in_bit[p] <= i[1];
      #1 j = i - 1;
      if (i > 0)
        chk("bypass", {6'h0, !j[0], !j[0] & j[1]},
            {6'h0, ja_out_valid[p], ja_out_bit[p] & ja_out_valid[p]});
    end
  endtask

  // overfill by four, then all but the dropped bits come out
  task automatic t_fifo(input int p, input logic [1:0] code);
    int d;
    int cnt;
    d = (code == 2'h0) ? 128 : (code == 2'h1) ? 64 : 32;
    wr(6'h02 + 6'(p), {4'h0, 1'h1, code, 1'h0});
    cyc(3);
    feed(p, d + 4);
    drain(p, d + 4, cnt);
    chk("depth", 8'(d), 8'(cnt));
    wr(6'h02 + 6'(p), 8'h00);
    cyc(3);
  endtask

  task automatic t_limit(input int p);
    int cnt;
    wr(6'h02 + 6'(p), 8'h1c);
    cyc(3);
    chk("slow", 8'h01, {7'h0, ja_slow_down[p]});
    feed(p, 2);
    drain(p, 1, cnt);
    chk("held", 8'h00, 8'(cnt));
    feed(p, 1);
    cyc(2);
    chk("mid", 8'h00, {6'h0, ja_speed_up[p], ja_slow_down[p]});
    feed(p, 27);
    cyc(2);
    chk("fast", 8'h02, {6'h0, ja_speed_up[p], ja_slow_down[p]});
    wr(6'h02 + 6'(p), 8'h00);
    cyc(3);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'h1;
    #1;
    t_regs();
    t_corner();
    t_soft();
    t_bypass(0);
    t_bypass(1);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
        t_fifo(p, 2'(c));
    t_limit(0);
    t_limit(1);
    finish_test();
  end

  // the whole sequence needs well under a fifth of this span
  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
